// [rtl/tcs_core.sv]
// Timing core sequencer top: fetch, execute, parameters and outputs.
//
// What this block does
// RL1: Everything runs on the master clock; reset and load come from backplane.
// RL2: A 2048-entry program memory holds op-codes with output states per step.
// RL3: The configurer loads identical op-codes into all modules; outputs may differ.
// RL4: Backplane reset restarts execution at program address zero.
// RL5: Sixty-four parameters serve as loop counts, jump conditions and decrement targets.
// RL6: Load pulse commits the staged parameter index and value synchronously.
// RL7: Each instruction completes in one cycle and sets outputs for it.
// RL8: Each output can be driven high, low, or kept from before.
// RL9: NOP applies its outputs for one cycle, then goes to next address.
// RL10: Jump loads a new address, always, on parameter non-zero, or on zero.
// RL11: Call pushes next address and active count, loads count, branches to target.
// RL12: Calls nest up to sixteen levels deep.
// RL13: Call count is immediate or parameter; a zero parameter skips the call.
// RL14: A call may also be gated by a condition on another parameter.
// RL15: Counts and parameters are twenty-bit quantities.
// RL16: Return decrements count; non-zero branches to target, zero pops stack.
// RL17: Any instruction may decrement one parameter, saturating at zero.
// RL18: The decrement lands before the next instruction executes, branch or not.
// RL19: Constant call counts are non-zero; only parameter counts may be zero.
// RL20: Stack overflow or underflow holds the address and sets a sticky error.
`timescale 1ns/1ps
module tcs_core (
  input wire logic CLK_IN,
  input wire logic RST_N_IN,
  input wire logic RUN_IN,
  input wire logic LOAD_IN,
  input wire tcs_pkg::tcs_pload_s STAGE_IN,
  input wire tcs_pkg::tcs_pwrite_s PROG_IN,
  output logic [tcs_pkg::OUT_W-1:0] OUTPUTS_OUT,
  output logic [tcs_pkg::ADDR_W-1:0] PC_OUT,
  output logic [tcs_pkg::SP_W-1:0] DEPTH_OUT,
  output logic STACK_ERR_OUT
);

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------

  // Tests a parameter value against a jump condition.
  function automatic logic cond_met(input logic [1:0] cond,
                                    input logic [tcs_pkg::VAL_W-1:0] val);
    logic result;
    result = 1'b0;
    case (cond)
      tcs_pkg::COND_ALWAYS: result = 1'b1;
      tcs_pkg::COND_NONZERO: result = (val != tcs_pkg::RESET_PARAM);
      tcs_pkg::COND_ZERO: result = (val == tcs_pkg::RESET_PARAM);
      default: result = 1'b1;
    endcase
    return result;
  endfunction

  // Decrements by one, staying at zero.
  function automatic logic [tcs_pkg::VAL_W-1:0] sat_dec(
      input logic [tcs_pkg::VAL_W-1:0] val);
    logic [tcs_pkg::VAL_W-1:0] result;
    result = val;
    if (val != tcs_pkg::RESET_PARAM) begin
      result = val - tcs_pkg::ONE_VAL;
    end
    return result;
  endfunction

  // ----------------------------------------------------------------
  // State and wiring
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    TCS_IDLE,
    TCS_PRIME,
    TCS_RUN
  } tcs_state_e;

  tcs_state_e state;
  tcs_state_e next_state;
  logic [tcs_pkg::ADDR_W-1:0] fetch_addr;
  logic [tcs_pkg::ADDR_W-1:0] next_fetch_addr;
  logic [tcs_pkg::ADDR_W-1:0] pc;
  logic [tcs_pkg::ADDR_W-1:0] next_pc;
  logic [tcs_pkg::VAL_W-1:0] count;
  logic [tcs_pkg::VAL_W-1:0] next_count;
  logic [tcs_pkg::SP_W-1:0] sp;
  logic [tcs_pkg::SP_W-1:0] next_sp;
  logic [tcs_pkg::OUT_W-1:0] outputs;
  logic [tcs_pkg::OUT_W-1:0] next_outputs;
  logic stack_err;
  logic next_stack_err;
  logic [tcs_pkg::VAL_W-1:0] params [tcs_pkg::PARAM_COUNT];
  logic [tcs_pkg::VAL_W-1:0] next_params [tcs_pkg::PARAM_COUNT];
  tcs_pkg::tcs_instr_s instr;
  tcs_pkg::tcs_frame_s top_frame;
  tcs_pkg::tcs_frame_s push_frame;
  logic push;
  logic exec;
  logic [tcs_pkg::ADDR_W-1:0] seq_addr;
  logic [tcs_pkg::VAL_W-1:0] call_count;
  logic [tcs_pkg::VAL_W-1:0] ret_count;

  // ----------------------------------------------------------------
  // Program memory and stack
  // ----------------------------------------------------------------

  // Program words are written during configuration through the write port.
  // RL2 program memory
  tcs_prog_mem u_prog (
    .clk_in(CLK_IN),
    .wr_en_in(PROG_IN.en),
    .wr_addr_in(PROG_IN.addr),
    .wr_data_in(PROG_IN.data),
    .rd_addr_in(next_fetch_addr),
    .rd_data_out(instr)
  );

  tcs_stack u_stack (
    .clk_in(CLK_IN),
    .push_in(push),
    .sp_in(sp),
    .push_data_in(push_frame),
    .top_out(top_frame)
  );

  // ----------------------------------------------------------------
  // Execute
  // ----------------------------------------------------------------

  // Decode and execute the fetched instruction in a single cycle.
  always_comb begin
    next_state = state;
    next_fetch_addr = fetch_addr;
    next_pc = pc;
    next_count = count;
    next_sp = sp;
    next_outputs = outputs;
    next_stack_err = stack_err;
    next_params = params;
    push = 1'b0;
    push_frame = '{ret_addr: tcs_pkg::RESET_ADDR, count: count};
    // A reset cycle never executes, so no parameter is decremented while restarting.
    exec = (state == TCS_RUN) && RUN_IN && RST_N_IN;
    seq_addr = fetch_addr + tcs_pkg::ONE_ADDR;
    call_count = instr.count_is_param ? params[instr.count[tcs_pkg::PIDX_W-1:0]] : instr.count;
    ret_count = count - tcs_pkg::ONE_VAL;
    case (state)
      TCS_IDLE: begin
        // RL4 restart at zero
        next_fetch_addr = tcs_pkg::RESET_ADDR;
        next_state = TCS_PRIME;
      end
      TCS_PRIME: begin
        next_state = TCS_RUN;
      end
      TCS_RUN: begin
        if (exec) begin
          // RL7 one cycle each
          next_pc = fetch_addr;
          // RL8 high low keep
          next_outputs = (outputs & instr.out_keep) | (instr.out_level & ~instr.out_keep);
          // RL9 sequential advance
          next_fetch_addr = seq_addr;
          case (instr.opcode)
            tcs_pkg::OP_NOP: begin
              next_fetch_addr = seq_addr;
            end
            tcs_pkg::OP_GOTO: begin
              // RL10 conditional jump
              if (cond_met(instr.cond, params[instr.cond_param])) begin
                next_fetch_addr = instr.target;
              end
            end
            tcs_pkg::OP_CALL: begin
              // RL13 RL14 call gating
              if (cond_met(instr.cond, params[instr.cond_param]) &&
                  (call_count != tcs_pkg::RESET_PARAM)) begin
                // RL12 RL20 overflow guard
                if (sp == tcs_pkg::FULL_SP) begin
                  next_fetch_addr = fetch_addr;
                  next_stack_err = 1'b1;
                end else begin
                  // RL11 push and branch
                  push = 1'b1;
                  push_frame = '{ret_addr: seq_addr, count: count};
                  next_sp = sp + tcs_pkg::ONE_SP;
                  next_count = call_count;
                  next_fetch_addr = instr.target;
                end
              end
            end
            tcs_pkg::OP_RETURN: begin
              // RL16 count down or pop
              if (ret_count != tcs_pkg::RESET_COUNT) begin
                next_count = ret_count;
                next_fetch_addr = instr.target;
              end else if (sp == tcs_pkg::RESET_SP) begin
                // RL20 underflow guard
                next_fetch_addr = fetch_addr;
                next_stack_err = 1'b1;
              end else begin
                next_sp = sp - tcs_pkg::ONE_SP;
                next_count = top_frame.count;
                next_fetch_addr = top_frame.ret_addr;
              end
            end
            default: begin
              next_fetch_addr = seq_addr;
            end
          endcase
          // RL17 RL18 saturating decrement
          if (instr.dec_en) begin
            next_params[instr.dec_param] = sat_dec(params[instr.dec_param]);
          end
        end
      end
      default: begin
        next_state = TCS_IDLE;
      end
    endcase
    // RL6 load commit
    if (LOAD_IN) begin
      next_params[STAGE_IN.index] = STAGE_IN.value;
    end
  end

  // RL1 master clock registers
  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      state <= TCS_IDLE;
      fetch_addr <= tcs_pkg::RESET_ADDR;
      pc <= tcs_pkg::RESET_ADDR;
      count <= tcs_pkg::RESET_COUNT;
      sp <= tcs_pkg::RESET_SP;
      outputs <= tcs_pkg::RESET_OUT;
      stack_err <= 1'b0;
    end else begin
      state <= next_state;
      fetch_addr <= next_fetch_addr;
      pc <= next_pc;
      count <= next_count;
      sp <= next_sp;
      outputs <= next_outputs;
      stack_err <= next_stack_err;
    end
  end

  // Parameters keep their values across a timing reset; only a load or an instruction's decrement changes them.
  // RL5 RL15 parameter bank
  always_ff @(posedge CLK_IN) begin
    params <= next_params;
  end

  assign OUTPUTS_OUT = outputs;
  assign PC_OUT = pc;
  assign DEPTH_OUT = sp;
  assign STACK_ERR_OUT = stack_err;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_call_taken;
    exec && instr.opcode == tcs_pkg::OP_CALL && push;
  endsequence

  sequence s_pushed;
    ##1 sp == $past(sp) + tcs_pkg::ONE_SP;
  endsequence

  // The priming cycle, then the first run cycle, both fetching from the restart address.
  sequence s_restart;
    (fetch_addr == tcs_pkg::RESET_ADDR && state == TCS_PRIME)
    ##1 (fetch_addr == tcs_pkg::RESET_ADDR && state == TCS_RUN);
  endsequence

  // RL4 restart at zero
  AST_RESET_ZERO: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN) // RL4
    $rose(RST_N_IN) |-> ##1 s_restart)
    else $error("Fetch did not restart at address zero.");

  // RL11 push on call
  AST_CALL_PUSH: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN) // RL11
    s_call_taken |-> s_pushed ##0 fetch_addr == $past(instr.target))
    else $error("Call did not push and branch.");

  // RL13 zero count skip
  AST_CALL_SKIP: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN) // RL13
    exec && instr.opcode == tcs_pkg::OP_CALL && call_count == tcs_pkg::RESET_PARAM
    |=> fetch_addr == $past(fetch_addr) + tcs_pkg::ONE_ADDR && sp == $past(sp))
    else $error("Call with zero count was not skipped.");

  // RL12 depth bound
  AST_DEPTH: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN) // RL12
    sp <= tcs_pkg::FULL_SP)
    else $error("Stack depth above sixteen.");

  // RL20 sticky error
  AST_ERR_STICKY: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN) // RL20
    stack_err |=> stack_err)
    else $error("Stack error flag cleared.");

  // RL9 nop advance
  AST_NOP_ADV: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN) // RL9
    exec && instr.opcode == tcs_pkg::OP_NOP
    |=> fetch_addr == $past(fetch_addr) + tcs_pkg::ONE_ADDR)
    else $error("Nop did not advance by one.");

  // RL8 keep outputs
  AST_KEEP: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN) // RL8
    exec |=> ((outputs ^ $past(outputs)) & $past(instr.out_keep)) == '0)
    else $error("Kept outputs changed.");

  // RL8 driven levels
  AST_LEVEL: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN) // RL8
    exec |=> (outputs & ~$past(instr.out_keep)) ==
    ($past(instr.out_level) & ~$past(instr.out_keep)))
    else $error("Driven outputs do not match the stored levels.");

  // RL16 return count down
  AST_RET_LOOP: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN) // RL16
    exec && instr.opcode == tcs_pkg::OP_RETURN && count > tcs_pkg::ONE_VAL
    |=> count == $past(count) - tcs_pkg::ONE_VAL && fetch_addr == $past(instr.target))
    else $error("Return did not loop back.");

  // RL17 saturating decrement
  AST_DEC: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN) // RL17
    exec && instr.dec_en && !LOAD_IN
    |=> params[$past(instr.dec_param)] == sat_dec($past(params[instr.dec_param])))
    else $error("Parameter decrement wrong.");

  // RL6 load commit
  AST_LOAD: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN) // RL6
    LOAD_IN |=> params[$past(STAGE_IN.index)] == $past(STAGE_IN.value))
    else $error("Staged parameter not committed.");

endmodule // tcs_core

// [rtl/tcs_pkg.sv]
// Package of constants, types and instruction layout for the timing core sequencer.
package tcs_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int PROG_DEPTH = 2048;
  localparam int ADDR_W = 11;
  localparam int PARAM_COUNT = 64;
  localparam int PIDX_W = 6;
  localparam int VAL_W = 20;
  localparam int STACK_DEPTH = 16;
  localparam int SP_W = 5;
  localparam int OUT_W = 16;
  localparam int OP_W = 3;

  // ----------------------------------------------------------------
  // Reset values, unit steps and the full stack pointer
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] RESET_ADDR = 11'h000;
  localparam logic [VAL_W-1:0] RESET_COUNT = 20'h00000;
  localparam logic [VAL_W-1:0] RESET_PARAM = 20'h00000;
  localparam logic [OUT_W-1:0] RESET_OUT = 16'h0000;
  localparam logic [SP_W-1:0] RESET_SP = 5'h00;
  localparam logic [VAL_W-1:0] ONE_VAL = 20'h00001;
  localparam logic [ADDR_W-1:0] ONE_ADDR = 11'h001;
  localparam logic [SP_W-1:0] ONE_SP = 5'h01;
  localparam logic [SP_W-1:0] FULL_SP = 5'h10;

  // ----------------------------------------------------------------
  // Op-codes and jump conditions
  // ----------------------------------------------------------------
  localparam logic [OP_W-1:0] OP_NOP = 3'h0;
  localparam logic [OP_W-1:0] OP_GOTO = 3'h1;
  localparam logic [OP_W-1:0] OP_CALL = 3'h2;
  localparam logic [OP_W-1:0] OP_RETURN = 3'h3;

  localparam logic [1:0] COND_ALWAYS = 2'h0;
  localparam logic [1:0] COND_NONZERO = 2'h1;
  localparam logic [1:0] COND_ZERO = 2'h2;

  // One program word: op-code, operands and the per-output drive fields.
  typedef struct packed {
    logic [OP_W-1:0] opcode;
    logic [1:0] cond;
    logic [PIDX_W-1:0] cond_param;
    logic count_is_param;
    logic [VAL_W-1:0] count;
    logic [ADDR_W-1:0] target;
    logic dec_en;
    logic [PIDX_W-1:0] dec_param;
    logic [OUT_W-1:0] out_level;
    logic [OUT_W-1:0] out_keep;
  } tcs_instr_s;

  localparam int INSTR_W = $bits(tcs_instr_s);

  // One stack frame: return address and saved active count.
  typedef struct packed {
    logic [ADDR_W-1:0] ret_addr;
    logic [VAL_W-1:0] count;
  } tcs_frame_s;

  // Staged parameter change from the backplane.
  typedef struct packed {
    logic [PIDX_W-1:0] index;
    logic [VAL_W-1:0] value;
  } tcs_pload_s;

  // Program write port.
  typedef struct packed {
    logic en;
    logic [ADDR_W-1:0] addr;
    tcs_instr_s data;
  } tcs_pwrite_s;

endpackage

// [rtl/tcs_prog_mem.sv]
// Program memory of the timing core with a registered read port.
`timescale 1ns/1ps
module tcs_prog_mem (
  input wire logic clk_in,
  input wire logic wr_en_in,
  input wire logic [tcs_pkg::ADDR_W-1:0] wr_addr_in,
  input wire tcs_pkg::tcs_instr_s wr_data_in,
  input wire logic [tcs_pkg::ADDR_W-1:0] rd_addr_in,
  output tcs_pkg::tcs_instr_s rd_data_out
);

  tcs_pkg::tcs_instr_s mem [tcs_pkg::PROG_DEPTH];

  // Write during configuration, read one word per clock.
  always_ff @(posedge clk_in) begin
    if (wr_en_in) begin
      mem[wr_addr_in] <= wr_data_in;
    end
    rd_data_out <= mem[rd_addr_in];
  end

endmodule // tcs_prog_mem

// [rtl/tcs_stack.sv]
// Call and return stack holding return addresses and active counts.
`timescale 1ns/1ps
module tcs_stack (
  input wire logic clk_in,
  input wire logic push_in,
  input wire logic [tcs_pkg::SP_W-1:0] sp_in,
  input wire tcs_pkg::tcs_frame_s push_data_in,
  output tcs_pkg::tcs_frame_s top_out
);

  tcs_pkg::tcs_frame_s mem [tcs_pkg::STACK_DEPTH];
  logic [tcs_pkg::SP_W-2:0] top_idx;

  // The top frame sits one below the stack pointer.
  assign top_idx = 4'(sp_in - tcs_pkg::ONE_SP);

  // A push writes the frame at the pointer slot.
  always_ff @(posedge clk_in) begin
    if (push_in) begin
      mem[sp_in[tcs_pkg::SP_W-2:0]] <= push_data_in;
    end
  end

  // The top frame is read without a clock so a return pops it at once.
  always_comb begin
    top_out = mem[top_idx];
  end

endmodule // tcs_stack

// [dv/tcs_backplane.sv]
// Backplane model that distributes the shared reset and staged parameter loads.
`timescale 1ns/1ps
module tcs_backplane (
  input wire logic rst_req_in,
  input wire logic load_req_in,
  input wire logic [tcs_pkg::PIDX_W-1:0] load_idx_in,
  input wire logic [tcs_pkg::VAL_W-1:0] load_val_in,
  output logic rst_n_out,
  output logic load_out,
  output tcs_pkg::tcs_pload_s stage_out
);
  // ----------------------------------------------------------------
  // Reset and load distribution
  // ----------------------------------------------------------------
  // shared reset line
  // The reset request is turned into the active-low backplane reset.
  assign rst_n_out = !rst_req_in;
  // stage then load
  // Outside a load the staged bus shows inverted data, so stale values never match.
  assign load_out = load_req_in;
  assign stage_out = load_req_in ? {load_idx_in, load_val_in} : ~{load_idx_in, load_val_in};
endmodule // tcs_backplane

// [dv/tb_top.sv]
// Self-checking testbench of the timing core sequencer against a behavioural model.
`timescale 1ns/1ps
module tb_top;
  logic clk = 1'b0;
  logic run = 1'b0;
  logic rst_req = 1'b1;
  logic load_req = 1'b0;
  logic [5:0] load_idx = 6'h00;
  logic [19:0] load_val = 20'h00000;
  tcs_pkg::tcs_pwrite_s prog_w = '0;
  logic rst_n;
  logic load;
  tcs_pkg::tcs_pload_s stage;
  logic [tcs_pkg::OUT_W-1:0] outs;
  logic [tcs_pkg::ADDR_W-1:0] pc;
  logic [tcs_pkg::SP_W-1:0] depth;
  logic err;
  int n_mismatch = 0;
  int checks_done = 0;
  int seed = 38;
  // Edges from reset release until the first instruction's outputs show.
  localparam int RESTART_EDGES = 32'h00000003;
  int ptab[10] = '{0, 5, 1, 3, 0, 2, 7, 0, 0, 1};
  tcs_pkg::tcs_instr_s prog[int];
  int m_pc, m_last, m_cnt;
  int m_par[64];
  int s_addr[$];
  int s_cnt[$];
  logic [15:0] m_out;
  bit m_err;

  // Master clock of 100 MHz.
  always #5 clk = ~clk;

  tcs_backplane u_bp (.rst_req_in(rst_req), .load_req_in(load_req), .load_idx_in(load_idx),
    .load_val_in(load_val), .rst_n_out(rst_n), .load_out(load), .stage_out(stage));

  tcs_core dut (.CLK_IN(clk), .RST_N_IN(rst_n), .RUN_IN(run), .LOAD_IN(load), .STAGE_IN(stage),
    .PROG_IN(prog_w), .OUTPUTS_OUT(outs), .PC_OUT(pc), .DEPTH_OUT(depth), .STACK_ERR_OUT(err));

  // ----------------------------------------------------------------
  // Checking and model
  // ----------------------------------------------------------------
  // Compares the timing outputs with the model.
  task automatic chk_out(logic [15:0] exp, logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] outputs expected %h seen %h", exp, got);
    end
  endtask

  // Compares the executed address with the model.
  task automatic chk_pc(logic [10:0] exp, logic [10:0] got);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] pc expected %h seen %h", exp, got);
    end
  endtask

  // Compares the stack depth with the model.
  task automatic chk_depth(logic [4:0] exp, logic [4:0] got);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] depth expected %h seen %h", exp, got);
    end
  endtask

  // Compares the sticky stack error with the model.
  task automatic chk_err(logic exp, logic got);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] error expected %h seen %h", exp, got);
    end
  endtask

  // Compares the restart latency in edges.
  task automatic chk_restart(int exp, int got);
    checks_done++;
    if (got != exp) begin
      n_mismatch++;
      $display("[FAIL] restart expected %0d seen %0d", exp, got);
    end
  endtask

  // Evaluates a jump or call condition on a parameter value.
  function automatic bit cond_ok(logic [1:0] c, int v);
    return (c == tcs_pkg::COND_NONZERO) ? (v != 0) : (c == tcs_pkg::COND_ZERO) ? (v == 0) : 1'b1;
  endfunction

  // Writes one program word with random output fields (fixed at address 0) and keeps a copy.
  task automatic put(int a, logic [2:0] op, logic [1:0] c, int cp, bit cip, int cnt, int tgt,
                     bit de, int dp);
    tcs_pkg::tcs_instr_s w;
    w = {op, c, 6'(cp), cip, 20'(cnt), 11'(tgt), de, 6'(dp), 16'($random(seed)),
         16'($random(seed))};
    if (a == 0) begin
      w.out_level = 16'ha5c3;
      w.out_keep = 16'h0000;
    end
    prog[a] = w;
    @(posedge clk);
    prog_w <= {1'b1, 11'(a), w};
  endtask

  // Executes one instruction in the model, then the decrement, then a load.
  task automatic step(bit ld, int li, int lv);
    tcs_pkg::tcs_instr_s i;
    int npc;
    int c;
    i = prog[m_pc];
    npc = m_pc + 1;
    m_last = m_pc;
    m_out = (m_out & i.out_keep) | (i.out_level & ~i.out_keep);
    c = i.count_is_param ? m_par[i.count[5:0]] : int'(i.count);
    case (i.opcode)
      tcs_pkg::OP_GOTO: if (cond_ok(i.cond, m_par[i.cond_param])) npc = i.target;
      tcs_pkg::OP_CALL: if (cond_ok(i.cond, m_par[i.cond_param]) && c != 0) begin
        if (s_addr.size() == 16) begin
          m_err = 1'b1;
          npc = m_pc;
        end else begin
          s_addr.push_back(npc);
          s_cnt.push_back(m_cnt);
          m_cnt = c;
          npc = i.target;
        end
      end
      tcs_pkg::OP_RETURN: if (m_cnt != 1) begin
        m_cnt = (m_cnt - 1) & 32'h000fffff;
        npc = i.target;
      end else if (s_addr.size() == 0) begin
        m_err = 1'b1;
        npc = m_pc;
      end else begin
        npc = s_addr.pop_back();
        m_cnt = s_cnt.pop_back();
      end
      default: ;
    endcase
    if (i.dec_en && m_par[i.dec_param] != 0) m_par[i.dec_param]--;
    if (ld) m_par[li] = lv;
    m_pc = npc;
  endtask

  // Resets the core, finds the first instruction, then runs and compares each cycle.
  task automatic run_pass(int cycles);
    int k;
    bit r;
    bit ld;
    int li;
    int lv;
    rst_req <= 1'b1;
    run <= 1'b0;
    repeat (12) @(posedge clk);
    rst_req <= 1'b0;
    run <= 1'b1;
    m_pc = 0;
    m_cnt = 0;
    s_addr.delete();
    s_cnt.delete();
    m_out = 16'h0000;
    m_err = 1'b0;
    k = 0;
    while (k < 20 && !(outs === 16'ha5c3 && pc === 11'h000)) begin
      @(posedge clk);
      #1;
      k++;
    end
    chk_restart(RESTART_EDGES, k);
    step(1'b0, 0, 0);
    for (k = 0; k < cycles; k++) begin
      @(posedge clk);
      r = run;
      ld = load_req;
      li = load_idx;
      lv = load_val;
      if (r) step(ld, li, lv);
      if (k < 64) begin
        run <= 1'b1;
        load_req <= 1'b1;
        load_idx <= 6'(k);
        load_val <= (k < 10) ? 20'(ptab[k]) : 20'($random(seed));
      end else begin
        load_req <= 1'b0;
        run <= ($random(seed) & 3) != 0;
      end
      #1;
      chk_out(m_out, outs);
      chk_pc(11'(m_last), pc);
      chk_depth(5'(s_addr.size()), depth);
      chk_err(m_err, err);
    end
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Stimulus
  // ----------------------------------------------------------------
  // Loads the program after reset with run low, then runs two passes with a mid-run reset.
  initial begin
    // Power-up reset; the program is then written while the core idles with run low.
    repeat (12) @(posedge clk);
    rst_req <= 1'b0;
    for (int a = 0; a < 74; a++) put(a, tcs_pkg::OP_NOP, 2'h0, 0, 1'b0, 0, 0, 1'b0, 0);
    // An undecoded op-code runs as a nop; condition code three always jumps.
    put(60, 3'h6, 2'h3, 0, 1'b0, 0, 0, 1'b0, 0);
    put(61, tcs_pkg::OP_GOTO, 2'h3, 0, 1'b0, 0, 63, 1'b0, 0);
    put(66, tcs_pkg::OP_CALL, tcs_pkg::COND_ZERO, 1, 1'b0, 1, 220, 1'b0, 0);
    put(67, tcs_pkg::OP_GOTO, tcs_pkg::COND_NONZERO, 0, 1'b0, 0, 220, 1'b0, 0);
    put(70, tcs_pkg::OP_GOTO, tcs_pkg::COND_NONZERO, 1, 1'b0, 0, 72, 1'b1, 2);
    put(72, tcs_pkg::OP_GOTO, tcs_pkg::COND_ZERO, 2, 1'b0, 0, 74, 1'b0, 0);
    put(74, tcs_pkg::OP_CALL, tcs_pkg::COND_ALWAYS, 0, 1'b0, 3, 200, 1'b1, 3);
    put(75, tcs_pkg::OP_CALL, tcs_pkg::COND_ALWAYS, 0, 1'b1, 4, 200, 1'b0, 0);
    put(76, tcs_pkg::OP_CALL, tcs_pkg::COND_NONZERO, 6, 1'b1, 5, 210, 1'b0, 0);
    put(77, tcs_pkg::OP_CALL, tcs_pkg::COND_ZERO, 9, 1'b0, 1, 220, 1'b0, 0);
    put(200, tcs_pkg::OP_NOP, 2'h0, 0, 1'b0, 0, 0, 1'b1, 9);
    put(201, tcs_pkg::OP_RETURN, 2'h0, 0, 1'b0, 0, 200, 1'b0, 0);
    put(210, tcs_pkg::OP_CALL, tcs_pkg::COND_ALWAYS, 0, 1'b0, 2, 200, 1'b0, 0);
    put(211, tcs_pkg::OP_RETURN, 2'h0, 0, 1'b0, 0, 210, 1'b0, 0);
    put(220, tcs_pkg::OP_CALL, tcs_pkg::COND_ALWAYS, 0, 1'b0, 1, 220, 1'b0, 0);
    @(posedge clk);
    prog_w <= '0;
    run_pass(260);
    run_pass(260);
    final_report();
  end

  // Cuts a hang short well beyond the expected run length.
  initial begin
    #20000;
    n_mismatch++;
    final_report();
  end
endmodule // tb_top
